// >>> mrs_crc16.v
// Byte-wide frame checksum register
`timescale 1ns/1ns
`include "mrs_regs.vh"
module mrs_crc16 (
   input wire core_clk,
   input wire reset_n,
   input wire clear,
   input wire enable,
   input wire [7:0] data,
   output reg [15:0] crc
);
   function [15:0] crc_byte;
      input [15:0] c;
      input [7:0] d;
      reg [15:0] t;
      integer i;
      begin
         t = c ^ {8'h00, d};
         for (i = 0; i < 8; i = i + 1) begin
            if (t[0]) begin
               t = (t >> 1) ^ `MRS_CRC_POLY;
            end else begin
               t = t >> 1;
            end
         end
         crc_byte = t;
      end
   endfunction

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         crc <= `MRS_CRC_INIT;
      end else if (clear) begin
         crc <= `MRS_CRC_INIT;
      end else if (enable) begin
         crc <= crc_byte(crc, data);
      end
   end
endmodule

// >>> mrs_master.sv
// Serial master model: sends checked queries and collects reply bytes
`timescale 1ns/1ns
module mrs_master (
   input wire core_clk,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_error,
   output logic rx_frame_end,
   output logic tx_ready,
   input wire tx_valid,
   input wire [7:0] tx_data
);
   logic [7:0] got[$];
   bit slow = 1'b0;
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      rx_error = 1'b0;
      rx_frame_end = 1'b0;
      tx_ready = 1'b0;
   end
   function automatic logic [15:0] crc16(input logic [7:0] b[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (b[i]) begin
         c = c ^ {8'h00, b[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
      end
      return c;
   endfunction
   task automatic send(input logic [7:0] b[$], input bit err, bad);
      logic [15:0] c;
      c = crc16(b) ^ {15'h0000, bad};
      b.push_back(c[7:0]);
      b.push_back(c[15:8]);
      rx_error <= err;
      foreach (b[i]) begin
         @(posedge core_clk);
         rx_valid <= 1'b1;
         rx_data <= b[i];
      end
      @(posedge core_clk);
      rx_valid <= 1'b0;
      // Released line must not look like a repeat of the last byte
      rx_data <= ~rx_data;
      @(posedge core_clk);
      rx_frame_end <= 1'b1;
      @(posedge core_clk);
      rx_frame_end <= 1'b0;
      rx_error <= 1'b0;
   endtask
   // Slow mode stalls the reply stream at random
   always @(posedge core_clk) begin
      if (tx_valid && tx_ready)
         got.push_back(tx_data);
      tx_ready <= slow ? 1'($urandom % 2) : 1'b1;
   end
endmodule

// >>> mrs_regs.vh
// Constants for the serial slave function handler
`ifndef MRS_REGS_VH
`define MRS_REGS_VH
`define MRS_FN_READ 8'h03
`define MRS_FN_WRITE1 8'h06
`define MRS_FN_DIAG 8'h08
`define MRS_FN_WRMULTI 8'h10
`define MRS_FN_LOG 8'h46
`define MRS_DIAG_SUB 16'h0000
`define MRS_EXC_FLAG 8'h80
`define MRS_EXC_FUNC 8'h01
`define MRS_EXC_ADDR 8'h02
`define MRS_EXC_VALUE 8'h03
`define MRS_BCAST 8'h00
`define MRS_CRC_INIT 16'hffff
`define MRS_CRC_POLY 16'ha001
`define MRS_MAX_REGS 16'h007d
`define MRS_MIN_FRAME 9'h004
`define MRS_DIAG_LEN 9'h008
`define MRS_WR_HDR_LEN 9'h009
`define MRS_WR_DATA_OFS 9'h007
`define MRS_BUF_DEPTH 9'h104
`define MRS_REG_BASE 16'h9c41
`endif

// >>> mrs_slave.v
// Slave function handler: diagnosis echo, multiple write, access log
`timescale 1ns/1ns
`include "mrs_regs.vh"
module mrs_slave (
   input wire core_clk,
   input wire reset_n,
   input wire [7:0] my_addr,
   input wire rx_valid,
   input wire [7:0] rx_data,
   input wire rx_error,
   input wire rx_frame_end,
   input wire rd_log_valid,
   input wire [15:0] rd_log_start,
   input wire [15:0] rd_log_count,
   input wire hr_exists,
   input wire tx_ready,
   output wire tx_valid,
   output wire [7:0] tx_data,
   output reg hr_wr,
   output reg [15:0] hr_addr,
   output reg [15:0] hr_wdata,
   output reg busy
);
   localparam [6:0] S_IDLE = 7'h01;
   localparam [6:0] S_CHECK = 7'h02;
   localparam [6:0] S_WRITE = 7'h04;
   localparam [6:0] S_WRWAIT = 7'h08;
   localparam [6:0] S_FINISH = 7'h10;
   localparam [6:0] S_REPLY = 7'h20;
   localparam [6:0] S_WAITTX = 7'h40;

   reg [7:0] fbuf [0:`MRS_BUF_DEPTH-1];
   reg [6:0] state;
   reg [8:0] cnt;
   reg rx_err;
   reg ovf;
   reg bcast;
   reg [6:0] wi;
   reg [6:0] reg_total;
   reg [6:0] ok_cnt;
   reg [15:0] first_ok;
   reg [15:0] start_addr;
   reg [15:0] log_start;
   reg [15:0] log_count;
   reg [47:0] resp;
   reg [2:0] resp_len;
   reg tx_start;
   reg crc_clr;
   wire [15:0] rx_crc;
   wire tx_busy;

   function [47:0] exc_resp;
      input [7:0] a;
      input [7:0] f;
      input [7:0] code;
      begin
         exc_resp = {24'h000000, code, f | `MRS_EXC_FLAG, a};
      end
   endfunction

   // Refused while busy, so the checksum clear after a frame cannot swallow a byte
   wire rx_take = rx_valid & state[0] & ~busy;
   wire [7:0] f_addr = fbuf[0];
   wire [7:0] f_fn = fbuf[1];
   wire [15:0] f_w2 = {fbuf[2], fbuf[3]};
   wire [15:0] f_w4 = {fbuf[4], fbuf[5]};
   wire [7:0] f_bc = fbuf[6];
   wire [47:0] f_head = {fbuf[5], fbuf[4], fbuf[3], fbuf[2], fbuf[1], fbuf[0]};
   // A good frame run through the checksum, its own checksum included, leaves zero
   wire frame_bad = rx_err | ovf | (cnt < `MRS_MIN_FRAME) | (rx_crc != 16'h0000);
   wire for_me = (f_addr == my_addr) | (f_addr == `MRS_BCAST);
   wire is_bcast = (f_addr == `MRS_BCAST);
   wire wr_ok = (f_w4 != 16'h0000) && (f_w4 <= `MRS_MAX_REGS) &&
                (f_bc == {f_w4[6:0], 1'b0}) &&
                (cnt == (`MRS_WR_HDR_LEN + {1'b0, f_bc}));
   wire [8:0] di = `MRS_WR_DATA_OFS + {1'b0, wi, 1'b0};
   wire [8:0] di_lo = di + 9'h001;

   mrs_crc16 u_rxcrc (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .clear(crc_clr),
      .enable(rx_take),
      .data(rx_data),
      .crc(rx_crc)
   );

   mrs_txq u_txq (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .start(tx_start),
      .len(resp_len),
      .payload(resp),
      .tx_ready(tx_ready),
      .tx_valid(tx_valid),
      .tx_data(tx_data),
      .busy(tx_busy)
   );

   // Frame store has no reset; only bytes below cnt are ever used
   always @(posedge core_clk) begin
      if (rx_take && (cnt < `MRS_BUF_DEPTH)) begin
         fbuf[cnt] <= rx_data;
      end
   end

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= S_IDLE;
         cnt <= 9'h000;
         rx_err <= 1'b0;
         ovf <= 1'b0;
         bcast <= 1'b0;
         wi <= 7'h00;
         reg_total <= 7'h00;
         ok_cnt <= 7'h00;
         first_ok <= 16'h0000;
         start_addr <= 16'h0000;
         log_start <= 16'h0000;
         log_count <= 16'h0000;
         resp <= 48'h0;
         resp_len <= 3'h0;
         tx_start <= 1'b0;
         crc_clr <= 1'b0;
         hr_wr <= 1'b0;
         hr_addr <= 16'h0000;
         hr_wdata <= 16'h0000;
         busy <= 1'b0;
      end else begin
         tx_start <= 1'b0;
         crc_clr <= 1'b0;
         hr_wr <= 1'b0;
         // The neighbouring read handler reports its own successful accesses
         if (rd_log_valid) begin
            log_start <= rd_log_start;
            log_count <= rd_log_count;
         end
         case (state)
            S_IDLE: begin
               busy <= 1'b0;
               if (rx_take) begin
                  if (cnt < `MRS_BUF_DEPTH) begin
                     cnt <= cnt + 9'h001;
                  end else begin
                     ovf <= 1'b1;
                  end
               end
               if (rx_error) begin
                  rx_err <= 1'b1;
               end
               if (rx_frame_end && !busy) begin
                  state <= S_CHECK;
                  busy <= 1'b1;
               end
            end
            S_CHECK: begin
               state <= S_IDLE;
               cnt <= 9'h000;
               rx_err <= 1'b0;
               ovf <= 1'b0;
               crc_clr <= 1'b1;
               bcast <= is_bcast;
               resp_len <= 3'h3;
               if (!frame_bad && for_me) begin
                  case (f_fn)
                     `MRS_FN_DIAG: begin
                        log_start <= 16'h0000;
                        log_count <= 16'h0000;
                        if (!is_bcast) begin
                           state <= S_REPLY;
                           if (f_w2 != `MRS_DIAG_SUB) begin
                              resp <= exc_resp(f_addr, f_fn, `MRS_EXC_FUNC);
                           end else if (cnt != `MRS_DIAG_LEN) begin
                              resp <= exc_resp(f_addr, f_fn, `MRS_EXC_VALUE);
                           end else begin
                              resp <= f_head;
                              resp_len <= 3'h6;
                           end
                        end
                     end
                     `MRS_FN_WRMULTI: begin
                        if (wr_ok) begin
                           // Field already holds register number minus base
                           start_addr <= f_w2;
                           reg_total <= f_w4[6:0];
                           wi <= 7'h00;
                           ok_cnt <= 7'h00;
                           first_ok <= 16'h0000;
                           state <= S_WRITE;
                        end else begin
                           log_start <= 16'h0000;
                           log_count <= 16'h0000;
                           resp <= exc_resp(f_addr, f_fn, `MRS_EXC_VALUE);
                           if (!is_bcast) begin
                              state <= S_REPLY;
                           end
                        end
                     end
                     `MRS_FN_LOG: begin
                        if (!is_bcast) begin
                           resp <= {log_count[7:0], log_count[15:8],
                                    log_start[7:0], log_start[15:8], f_fn, f_addr};
                           resp_len <= 3'h6;
                           state <= S_REPLY;
                        end
                     end
                     `MRS_FN_READ: begin
                     end
                     `MRS_FN_WRITE1: begin
                        log_start <= 16'h0000;
                        log_count <= 16'h0000;
                     end
                     default: begin
                        log_start <= 16'h0000;
                        log_count <= 16'h0000;
                        resp <= exc_resp(f_addr, f_fn, `MRS_EXC_FUNC);
                        if (!is_bcast) begin
                           state <= S_REPLY;
                        end
                     end
                  endcase
               end
            end
            S_WRITE: begin
               hr_wr <= 1'b1;
               hr_addr <= start_addr + {9'h000, wi};
               hr_wdata <= {fbuf[di], fbuf[di_lo]};
               state <= S_WRWAIT;
            end
            S_WRWAIT: begin
               // Missing registers ignore the write; only the count of hits and the first hit address matter
               if (hr_exists) begin
                  ok_cnt <= ok_cnt + 7'h01;
                  if (ok_cnt == 7'h00) begin
                     first_ok <= hr_addr;
                  end
               end
               if (wi == (reg_total - 7'h01)) begin
                  state <= S_FINISH;
               end else begin
                  wi <= wi + 7'h01;
                  state <= S_WRITE;
               end
            end
            S_FINISH: begin
               state <= bcast ? S_IDLE : S_REPLY;
               if (ok_cnt == 7'h00) begin
                  log_start <= 16'h0000;
                  log_count <= 16'h0000;
                  resp <= exc_resp(f_addr, f_fn, `MRS_EXC_ADDR);
                  resp_len <= 3'h3;
               end else begin
                  log_start <= first_ok;
                  log_count <= {9'h000, ok_cnt};
                  resp <= f_head;
                  resp_len <= 3'h6;
               end
            end
            S_REPLY: begin
               tx_start <= 1'b1;
               state <= S_WAITTX;
            end
            S_WAITTX: begin
               if (!tx_start && !tx_busy) begin
                  state <= S_IDLE;
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end
endmodule

// >>> mrs_slave_chk.sv
// Port checker for the slave function handler
`timescale 1ns/1ns
module mrs_slave_chk (
   input wire core_clk,
   input wire reset_n,
   input wire [7:0] my_addr,
   input wire rx_valid,
   input wire [7:0] rx_data,
   input wire rx_frame_end,
   input wire tx_ready,
   input wire tx_valid,
   input wire [7:0] tx_data,
   input wire hr_wr,
   input wire [15:0] hr_addr,
   input wire busy
);
   reg [7:0] frame_addr;
   reg in_frame;
   reg first_due;
   // Address byte of the frame being answered, for the reply checks
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         frame_addr <= 8'h00;
         in_frame <= 1'b0;
         first_due <= 1'b0;
      end else begin
         if (rx_frame_end)
            in_frame <= 1'b0;
         else if (rx_valid && !busy && !in_frame) begin
            frame_addr <= rx_data;
            in_frame <= 1'b1;
         end
         if (rx_frame_end && !busy)
            first_due <= 1'b1;
         else if (tx_valid && tx_ready)
            first_due <= 1'b0;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   sequence s_frame_done;
      rx_frame_end && !busy;
   endsequence
   sequence s_wr_pair;
      hr_wr ##2 hr_wr;
   endsequence
   busy_after_end_a: assert property (s_frame_done |=> busy) else $error("busy missing after frame end");
   reply_delay_a: assert property (s_frame_done |=> !tx_valid [*3]) else $error("reply too early");
   tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("tx byte lost");
   tx_gap_a: assert property (tx_valid && tx_ready |=> !tx_valid) else $error("no gap after accept");
   no_bcast_reply_a: assert property (tx_valid |-> frame_addr != 8'h00) else $error("broadcast answered");
   own_addr_a: assert property (tx_valid |-> frame_addr == my_addr && busy) else $error("foreign reply");
   reply_addr_a: assert property (tx_valid && first_due |-> tx_data == frame_addr) else $error("bad reply address");
   wr_pulse_a: assert property (hr_wr |=> !hr_wr && busy) else $error("write pulse too long");
   wr_ascend_a: assert property (s_wr_pair |-> hr_addr == $past(hr_addr, 2) + 16'h0001) else $error("write order");
endmodule
bind mrs_slave mrs_slave_chk chk (.core_clk, .reset_n, .my_addr, .rx_valid, .rx_data, .rx_frame_end, .tx_ready,
   .tx_valid, .tx_data, .hr_wr, .hr_addr, .busy);

// >>> mrs_txq.v
// Reply sender that appends the checksum, low byte first
`timescale 1ns/1ns
`include "mrs_regs.vh"
module mrs_txq (
   input wire core_clk,
   input wire reset_n,
   input wire start,
   input wire [2:0] len,
   input wire [47:0] payload,
   input wire tx_ready,
   output reg tx_valid,
   output reg [7:0] tx_data,
   output reg busy
);
   reg [47:0] pay;
   reg [2:0] n;
   reg [3:0] idx;
   wire [15:0] crc;
   wire take = tx_valid & tx_ready;

   mrs_crc16 u_crc (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .clear(start),
      .enable(take & (idx < {1'b0, n})),
      .data(tx_data),
      .crc(crc)
   );

   // One idle cycle per byte lets the checksum settle before its bytes go out
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pay <= 48'h0;
         n <= 3'h0;
         idx <= 4'h0;
         busy <= 1'b0;
         tx_valid <= 1'b0;
         tx_data <= 8'h00;
      end else if (start) begin
         pay <= payload;
         n <= len;
         idx <= 4'h0;
         busy <= 1'b1;
         tx_valid <= 1'b1;
         tx_data <= payload[7:0];
      end else if (busy) begin
         if (take) begin
            idx <= idx + 4'h1;
            tx_valid <= 1'b0;
         end else if (!tx_valid) begin
            if (idx < ({1'b0, n} + 4'h2)) begin
               tx_valid <= 1'b1;
               if (idx < {1'b0, n}) begin
                  tx_data <= pay[{idx[2:0], 3'b000} +: 8];
               end else if (idx == {1'b0, n}) begin
                  tx_data <= crc[7:0];
               end else begin
                  tx_data <= crc[15:8];
               end
            end else begin
               busy <= 1'b0;
            end
         end
      end
   end
endmodule

// >>> tb_modbus_rtu_slave_function_handler.sv
// Self-checking bench for the slave function handler
`timescale 1ns/1ns
module tb_modbus_rtu_slave_function_handler;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic rd_log_valid = 1'b0;
   logic [7:0] my_addr = 8'h19;
   logic [15:0] rd_log_start = 16'h0000;
   logic [15:0] rd_log_count = 16'h0000;
   logic [15:0] hr_lim = 16'hffff;
   wire rx_valid, rx_error, rx_frame_end, tx_ready, tx_valid, hr_wr, busy, hr_exists;
   wire [7:0] rx_data, tx_data;
   wire [15:0] hr_addr, hr_wdata;
   int num_errors = 0;
   int total_checks = 0;
   logic [31:0] wlog[$];
   logic [7:0] nil[$];
   // Register file model: numbers below hr_lim exist
   assign hr_exists = hr_addr < hr_lim;
   initial begin
      forever #20 core_clk = ~core_clk;
   end
   always @(posedge core_clk) if (hr_wr) wlog.push_back({hr_addr, hr_wdata});
   mrs_slave DUT (.core_clk, .reset_n, .my_addr, .rx_valid, .rx_data, .rx_error, .rx_frame_end, .rd_log_valid,
      .rd_log_start, .rd_log_count, .hr_exists, .tx_ready, .tx_valid, .tx_data, .hr_wr, .hr_addr, .hr_wdata, .busy);
   mrs_master m (.core_clk, .rx_valid, .rx_data, .rx_error, .rx_frame_end, .tx_ready, .tx_valid, .tx_data);
   task automatic check(input string name, input logic [15:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Next query only once busy has dropped
   task automatic run(input logic [7:0] q[$], e[$], input bit err = 1'b0, bad = 1'b0);
      int i;
      logic [15:0] c;
      m.got.delete();
      m.send(q, err, bad);
      @(posedge core_clk);
      for (i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge core_clk);
      if (i == 3000) begin
         num_errors++;
         summarize();
      end else begin
         if (e.size() > 0) begin
            c = m.crc16(e);
            e.push_back(c[7:0]);
            e.push_back(c[15:8]);
         end
         check("reply_len", 16'(m.got.size()), 16'(e.size()));
         foreach (e[k]) check("reply_byte", {8'h00, m.got[k]}, {8'h00, e[k]});
      end
   endtask
   task automatic logq(input logic [15:0] s, n);
      run({my_addr, 8'h46}, {my_addr, 8'h46, s[15:8], s[7:0], n[15:8], n[7:0]});
   endtask
   initial begin
      repeat (100000) @(posedge core_clk);
      num_errors++;
      summarize();
   end
   initial begin
      logic [7:0] q[$], e[$], a;
      logic [15:0] s, d, n;
      logic [15:0] wd[$];
      int k, i;
      void'($urandom(42));
      repeat (16) @(posedge core_clk);
      reset_n <= 1'b1;
      for (k = 0; k < 4; k++) begin
         m.slow = k[0];
         d = k == 0 ? 16'h0000 : k == 1 ? 16'hffff : 16'($urandom);
         q = {my_addr, 8'h08, 8'h00, 8'h00, d[15:8], d[7:0]};
         run(q, q);
      end
      run({8'h00, 8'h08, 8'h00, 8'h00, 8'h55, 8'haa}, nil);
      run({8'h00, 8'h46}, nil);
      for (k = 0; k < 5; k++) begin
         m.slow = k[0];
         n = k == 0 ? 16'h0001 : k == 1 ? 16'h007d : k == 3 ? 16'h0004 : 16'(1 + $urandom % 6);
         s = 16'($urandom % 4096);
         hr_lim <= k == 3 ? s + 16'h0002 : 16'hffff;
         a = k == 4 ? 8'h00 : my_addr;
         q = {a, 8'h10, s[15:8], s[7:0], n[15:8], n[7:0], 8'(2 * n)};
         wd.delete();
         for (i = 0; i < n; i++) begin
            d = 16'($urandom);
            wd.push_back(d);
            q.push_back(d[15:8]);
            q.push_back(d[7:0]);
         end
         wlog.delete();
         e = {a, 8'h10, s[15:8], s[7:0], n[15:8], n[7:0]};
         if (k == 4) e.delete();
         run(q, e);
         check("write_count", 16'(wlog.size()), n);
         foreach (wd[j]) check("write_addr", wlog[j][31:16], s + 16'(j));
         foreach (wd[j]) check("write_data", wlog[j][15:0], wd[j]);
         if (k < 4) logq(s, k == 3 ? 16'h0002 : n);
      end
      m.slow = 1'b0;
      hr_lim <= 16'h0000;
      run({my_addr, 8'h10, 8'h00, 8'h05, 8'h00, 8'h01, 8'h02, 8'hbe, 8'hef}, {my_addr, 8'h90, 8'h02});
      hr_lim <= 16'hffff;
      run({my_addr, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, {my_addr, 8'h90, 8'h03});
      run({my_addr, 8'h10, 8'h00, 8'h00, 8'h00, 8'h02, 8'h05, 8'h00, 8'h01, 8'h00, 8'h02},
         {my_addr, 8'h90, 8'h03});
      run({my_addr, 8'h2b}, {my_addr, 8'hab, 8'h01});
      run({my_addr, 8'h08, 8'h00, 8'h01, 8'h12, 8'h34}, {my_addr, 8'h88, 8'h01});
      logq(16'h0000, 16'h0000);
      rd_log_start <= 16'($urandom);
      rd_log_count <= 16'h0001 + 16'($urandom % 125);
      rd_log_valid <= 1'b1;
      @(posedge core_clk);
      rd_log_valid <= 1'b0;
      q = {my_addr, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34};
      run(q, nil, 1'b1);
      run(q, nil, 1'b0, 1'b1);
      run({8'h33, 8'h46}, nil);
      logq(rd_log_start, rd_log_count);
      run({my_addr, 8'h03, 8'h00, 8'h01, 8'h00, 8'h02}, nil);
      logq(rd_log_start, rd_log_count);
      run({my_addr, 8'h06, 8'h00, 8'h01, 8'h12, 8'h34}, nil);
      logq(16'h0000, 16'h0000);
      summarize();
   end
endmodule
